// ==== dv/card_config_registers_properties.sv ====
/*
 * port assertions for the card configuration register bank
 * assumes it is bound to card_config_registers, one clock, sync reset
 */
`timescale 1ns/100ps
module card_config_registers_properties
    import card_config_pkg::*;
(
    input wire logic          ref_clk,
    input wire logic          rst_n,
    input wire av_req_s       avReq,
    input wire logic [31:0]   avReadData,
    input wire logic          avWaitRequest,
    input wire logic          selectValid,
    input wire logic [15:0]   selectAddr,
    input wire logic          cardSelected,
    input wire logic [15:0]   relativeCardAddress,
    input wire logic [15:0]   driverStage,
    input wire version_info_s versionInfo
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic rdDone;
    assign rdDone = avReq.read && !avWaitRequest;

    property p_rca_reset; $rose(rst_n) |-> relativeCardAddress == RCA_RESET; endproperty
    a_rca_reset: assert property (p_rca_reset) else $error("address reset wrong");
    property p_dsr_reset; $rose(rst_n) |-> driverStage == DSR_RESET; endproperty
    a_dsr_reset: assert property (p_dsr_reset) else $error("driver reset wrong");
    property p_answer; (avReq.read || avReq.write) && avWaitRequest |=> !avWaitRequest; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_wait_pulse; !avWaitRequest |=> avWaitRequest; endproperty
    a_wait_pulse: assert property (p_wait_pulse) else $error("wait low too long");
    // the port copy trails the bus write by one more edge
    property p_rca_write;
        avReq.write && !avWaitRequest && avReq.address == OFS_RCA && avReq.byteEnable == 4'hf
        |-> ##2 relativeCardAddress == $past(avReq.writeData[15:0], 2);
    endproperty
    a_rca_write: assert property (p_rca_write) else $error("address write lost");
    property p_select;
        selectValid && selectAddr != RCA_DESELECT && selectAddr == relativeCardAddress
        |=> cardSelected;
    endproperty
    a_select: assert property (p_select) else $error("select ignored");
    property p_deselect; selectValid && selectAddr == RCA_DESELECT |=> !cardSelected; endproperty
    a_deselect: assert property (p_deselect) else $error("deselect ignored");
    property p_hold; !selectValid |=> $stable(cardSelected); endproperty
    a_hold: assert property (p_hold) else $error("select state moved");
    property p_cfg_hi;
        rdDone && avReq.address == OFS_SCR_HI |-> avReadData[31:28] == CFG_LAYOUT_V1 && !avReadData[5];
    endproperty
    a_cfg_hi: assert property (p_cfg_hi) else $error("config layout wrong");
    property p_csd_mid;
        rdDone && avReq.address == OFS_CSD_W1
        |-> avReadData[13:7] == SECTOR_SPAN && avReadData[6:0] == PROTECT_SPAN;
    endproperty
    a_csd_mid: assert property (p_csd_mid) else $error("sector fields wrong");
    property p_csd_top; rdDone && avReq.address == OFS_CSD_W3 |-> avReadData[31:30] == 2'h2; endproperty
    a_csd_top: assert property (p_csd_top) else $error("data layout wrong");
    property p_ver_stable; $stable(versionInfo); endproperty
    a_ver_stable: assert property (p_ver_stable) else $error("version moved");
endmodule : card_config_registers_properties

// ==== dv/card_config_registers_tb.sv ====
/*
 * self-checking bench for the card configuration register bank
 * assumes the checker and host model files are compiled before it
 */
`timescale 1ns/100ps
module card_config_registers_tb
    import card_config_pkg::*;
;
    // below the floor on purpose: the field must read as the minimum
    localparam logic [27:0] CAP_LOW = 28'h0123456;
    localparam logic [5:0]  RO_OFS [8] = '{OFS_CSD_W0, OFS_CSD_W1, OFS_CSD_W2, OFS_CSD_W3,
                                           OFS_SCR_LO, OFS_SCR_HI, OFS_STATUS, OFS_CAPACITY};
    localparam logic [31:0] RO_VAL [8] = '{32'h0a400001, 32'h00007f80, 32'h5b591040,
                                           32'h800e0032, 32'h00000000, 32'h02058140,
                                           32'h0000004f, {3'h0, {1'b0, CAP_MIN} + 29'h1}};
    localparam logic [3:0]  V_BASE [5] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h3};
    localparam logic        V_V34  [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    localparam logic [7:0]  V_EXP  [5] = '{8'h08, 8'h0c, 8'h17, 8'h27, 8'h80};
    localparam logic [7:0]  V_MASK [5] = '{8'hfe, 8'hfe, 8'hff, 8'hff, 8'h80};
    logic          ref_clk;
    logic          rst_n = 1'b0;
    av_req_s       avReq = '0;
    logic [31:0]   avReadData;
    logic          avWaitRequest;
    logic          selectValid;
    logic [15:0]   selectAddr;
    logic          cardSelected;
    logic [15:0]   relativeCardAddress;
    logic [15:0]   driverStage;
    version_info_s versionInfo;
    version_info_s verRow [5];
    logic [31:0]   rd;
    int            failCount = 0;
    int            nCompared = 0;
    int            cycles = 0;

    card_config_registers #(.CAPACITY_SIZE(CAP_LOW)) card_config_registers_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .avReq(avReq), .avReadData(avReadData),
        .avWaitRequest(avWaitRequest), .selectValid(selectValid), .selectAddr(selectAddr),
        .cardSelected(cardSelected), .relativeCardAddress(relativeCardAddress),
        .driverStage(driverStage), .versionInfo(versionInfo));
    card_host_model card_host_model_i (.ref_clk(ref_clk), .selectValid(selectValid),
        .selectAddr(selectAddr));
    for (genvar k = 0; k < 5; k++)
    begin : g_ver
        card_config_registers #(.BASE_SPEC(V_BASE[k]), .SPEC3_FLAG(V_V34[k]),
            .SPEC4_FLAG(V_V34[k]), .SPEC_EXT(4'h0)) card_config_registers_i (
            .ref_clk(ref_clk), .rst_n(rst_n), .avReq(avReq), .avReadData(), .avWaitRequest(),
            .selectValid(selectValid), .selectAddr(selectAddr), .cardSelected(),
            .relativeCardAddress(), .driverStage(), .versionInfo(verRow[k]));
    end

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic stopTest();
        if (failCount == 0 && nCompared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stopTest

    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            failCount++;
            stopTest();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        nCompared++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            failCount++;
        end
    endtask : chk

    // request held until waitrequest is seen low, then one idle cycle
    task automatic busCycle(input logic [5:0] a, input logic wr, input logic [31:0] wd);
        avReq.address    <= a;
        avReq.read       <= !wr;
        avReq.write      <= wr;
        avReq.writeData  <= wd;
        avReq.byteEnable <= 4'hf;
        do @(posedge ref_clk); while (avWaitRequest !== 1'b0);
        rd = avReadData;
        avReq.read  <= 1'b0;
        avReq.write <= 1'b0;
        @(posedge ref_clk);
    endtask : busCycle

    task automatic rc(input string nm, input logic [5:0] a, input logic [31:0] exp);
        busCycle(a, 1'b0, 32'h0);
        chk(nm, exp, rd);
    endtask : rc

    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rc("address reset", OFS_RCA, 32'h0);
        rc("driver reset", OFS_DSR, 32'h0404);
        for (int k = 0; k < 8; k++)
            rc("fixed word", RO_OFS[k], RO_VAL[k]);
        for (int k = 0; k < 8; k++)
        begin
            busCycle(RO_OFS[k], 1'b1, 32'hffffffff);
            rc("read only word", RO_OFS[k], RO_VAL[k]);
        end
        for (int k = 0; k < 5; k++)
            chk("version", {24'h0, V_EXP[k]}, {24'h0, verRow[k] & V_MASK[k]});
        busCycle(6'h3c, 1'b1, 32'hffffffff);
        rc("unmapped", 6'h3c, 32'h0);
        busCycle(OFS_RCA, 1'b1, 32'hffffbeef);
        rc("address readback", OFS_RCA, 32'h0000beef);
        busCycle(OFS_DSR, 1'b1, 32'h00001234);
        rc("driver readback", OFS_DSR, 32'h00001234);
        chk("address port", 32'hbeef, {16'h0, relativeCardAddress});
        chk("driver port", 32'h1234, {16'h0, driverStage});
        card_host_model_i.issueSelect(16'h1234);
        chk("other card", 32'h0, {31'h0, cardSelected});
        card_host_model_i.issueSelect(16'hbeef);
        chk("this card", 32'h1, {31'h0, cardSelected});
        rc("status", OFS_STATUS, 32'h0000014f);
        chk("version port", 32'h0000004f, {24'h0, versionInfo});
        card_host_model_i.issueSelect(16'h0000);
        chk("deselect", 32'h0, {31'h0, cardSelected});
        rst_n <= 1'b0;
        @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rc("address rereset", OFS_RCA, 32'h0);
        rc("driver rereset", OFS_DSR, 32'h0404);
        stopTest();
    end
endmodule : card_config_registers_tb

bind card_config_registers card_config_registers_properties card_config_registers_properties_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .avReq(avReq), .avReadData(avReadData),
    .avWaitRequest(avWaitRequest), .selectValid(selectValid), .selectAddr(selectAddr),
    .cardSelected(cardSelected), .relativeCardAddress(relativeCardAddress),
    .driverStage(driverStage), .versionInfo(versionInfo));

// ==== dv/card_host_model.sv ====
/*
 * host controller stand-in issuing card select commands
 * assumes calls start just after a rising edge of ref_clk
 */
`timescale 1ns/100ps
module card_host_model (
    input  wire logic   ref_clk,
    output logic        selectValid,
    output logic [15:0] selectAddr
);
    initial
    begin
        selectValid = 1'b0;
        selectAddr  = 16'h0000;
    end

    // address 0000 deselects every card, so it goes out like any other
    task automatic issueSelect(input logic [15:0] addr);
        selectValid <= 1'b1;
        selectAddr  <= addr;
        @(posedge ref_clk);
        selectValid <= 1'b0;
        // a released line must not keep showing the old address
        selectAddr  <= ~addr;
        @(posedge ref_clk);
    endtask : issueSelect
endmodule : card_host_model

// ==== verilog/card_config_pkg.sv ====
/*
 * constants, field layouts and carrier types for the card configuration
 * register bank; assumes a 32-bit Avalon-MM slave with byte addressing
 */
package card_config_pkg;

    // avalon register map, byte offsets of aligned words
    localparam int          ADDR_W        = 6;
    localparam logic [5:0]  OFS_CSD_W0    = 6'h00;
    localparam logic [5:0]  OFS_CSD_W1    = 6'h04;
    localparam logic [5:0]  OFS_CSD_W2    = 6'h08;
    localparam logic [5:0]  OFS_CSD_W3    = 6'h0c;
    localparam logic [5:0]  OFS_RCA       = 6'h10;
    localparam logic [5:0]  OFS_DSR       = 6'h14;
    localparam logic [5:0]  OFS_SCR_LO    = 6'h18;
    localparam logic [5:0]  OFS_SCR_HI    = 6'h1c;
    localparam logic [5:0]  OFS_STATUS    = 6'h20;
    localparam logic [5:0]  OFS_CAPACITY  = 6'h24;

    // reset values and the deselect address
    localparam logic [15:0] RCA_RESET     = 16'h0000;
    localparam logic [15:0] RCA_DESELECT  = 16'h0000;
    localparam logic [15:0] DSR_RESET     = 16'h0404;

    // capacity size field limits for layout version 3.0
    localparam int          CAP_W         = 28;
    localparam logic [27:0] CAP_MIN       = 28'h0400000;
    localparam logic [27:0] CAP_MAX       = 28'hfffffff;
    localparam int          CAP_UNIT_KB   = 512;

    // fixed card specific data fields
    localparam logic [1:0]  CSD_LAYOUT_V3 = 2'h2;
    localparam logic [7:0]  CSD_ACCESS_T  = 8'h0e;
    localparam logic [7:0]  CSD_ACCESS_N  = 8'h00;
    localparam logic [7:0]  CSD_SPEED     = 8'h32;
    localparam logic [3:0]  CSD_BLK_LEN   = 4'h9;
    localparam logic [6:0]  SECTOR_SPAN   = 7'h7f;
    localparam logic [6:0]  PROTECT_SPAN  = 7'h00;
    localparam logic        PROTECT_ON    = 1'b0;
    localparam logic [2:0]  CSD_R2W       = 3'h2;

    // configuration register layout version and spec version codes
    localparam logic [3:0]  CFG_LAYOUT_V1 = 4'h0;
    localparam logic [3:0]  BASE_V1_0     = 4'h0;
    localparam logic [3:0]  BASE_V1_1     = 4'h1;
    localparam logic [3:0]  BASE_V2_0     = 4'h2;
    localparam logic [3:0]  EXT_V_MAX     = 4'h5;
    localparam logic [3:0]  MAJOR_EXT_OFS = 4'h4;

    typedef struct packed {
        logic [3:0]  configLayoutVersion;   // 63:60
        logic [3:0]  baseSpecVersion;       // 59:56
        logic        dataAfterErase;        // 55
        logic [2:0]  copyProtectLevel;      // 54:52
        logic [3:0]  supportedLaneWidths;   // 51:48
        logic        version3Flag;          // 47
        logic [3:0]  extendedProtection;    // 46:43
        logic        version4Flag;          // 42
        logic [3:0]  extendedSpecVersion;   // 41:38
        logic        reservedBit;           // 37
        logic [4:0]  commandSupport;        // 36:32
        logic [31:0] makerWord;             // 31:0
    } card_configuration_s;

    typedef struct packed {
        logic        reserved;
        logic [3:0]  majorVersion;
        logic        functionSwitchCmd;
        logic        interfaceConditionCmd;
        logic        lockUnlockCmd;
    } version_info_s;

    typedef struct packed {
        logic [5:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writeData;
        logic [3:0]  byteEnable;
    } av_req_s;

    typedef enum logic [1:0] {
        CARD_STANDBY  = 2'b00,
        CARD_TRANSFER = 2'b01
    } card_state_e;

endpackage : card_config_pkg

// ==== verilog/card_config_registers.sv ====
/*
 * card configuration and identification registers behind an Avalon-MM
 * slave with waitrequest: card specific data, relative address, driver
 * stage and configuration register, plus version decode and card select.
 * assumes select requests come from logic on ref_clk and that the master
 * holds each request until it samples waitrequest low.
 */
`timescale 1ns/100ps
module card_config_registers
    import card_config_pkg::*;
#(
    parameter logic [27:0] CAPACITY_SIZE  = 28'h0400000,
    parameter logic        DRIVER_PRESENT = 1'b1,
    parameter logic [11:0] COMMAND_CLASS  = 12'h5b5,
    parameter logic [6:0]  CSD_CRC        = 7'h00,
    parameter logic [3:0]  BASE_SPEC      = 4'h2,
    parameter logic        SPEC3_FLAG     = 1'b1,
    parameter logic        SPEC4_FLAG     = 1'b0,
    parameter logic [3:0]  SPEC_EXT       = 4'h5,
    parameter logic        ERASE_VALUE    = 1'b0,
    parameter logic [2:0]  PROTECT_LEVEL  = 3'h0,
    parameter logic [3:0]  LANE_WIDTHS    = 4'h5,
    parameter logic [3:0]  EXT_PROTECT    = 4'h0,
    parameter logic [4:0]  CMD_SUPPORT    = 5'h00,
    parameter logic [31:0] MAKER_WORD     = 32'h00000000   // arbitrary value
)(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire av_req_s     avReq,
    output logic [31:0]      avReadData,
    output logic             avWaitRequest,
    input  wire logic        selectValid,
    input  wire logic [15:0] selectAddr,
    output logic             cardSelected,
    output logic [15:0]      relativeCardAddress,
    output logic [15:0]      driverStage,
    output version_info_s    versionInfo
);

    // codes of the version decode; the major number is the integer part
    localparam logic [3:0]  EXT_NONE    = 4'h0;
    localparam logic [3:0]  MAJOR_ONE   = 4'h1;
    localparam logic [3:0]  MAJOR_TWO   = 4'h2;
    localparam logic [3:0]  MAJOR_THREE = 4'h3;
    localparam logic [3:0]  MAJOR_FOUR  = 4'h4;
    // an absent driver stage reads zero from reset on, so no host
    // mistakes a missing register for one that holds its default
    localparam logic [15:0] DSR_START   = DRIVER_PRESENT ? DSR_RESET : 16'h0000;

    // a build value below the floor is raised to it; 28 bits cap the top
    function automatic logic [27:0] clampCapacity(input logic [27:0] c);
        if (c < CAP_MIN)
            return CAP_MIN;
        return c;
    endfunction : clampCapacity

    function automatic version_info_s decodeVersion(input card_configuration_s s);
        version_info_s v;
        v = '0;
        v.reserved = 1'b1;
        if (s.baseSpecVersion == BASE_V1_0 && !s.version3Flag && !s.version4Flag
            && s.extendedSpecVersion == EXT_NONE)
        begin
            v.reserved     = 1'b0;
            v.majorVersion = MAJOR_ONE;
        end
        else if (s.baseSpecVersion == BASE_V1_1 && !s.version3Flag
                 && !s.version4Flag && s.extendedSpecVersion == EXT_NONE)
        begin
            v.reserved          = 1'b0;
            v.majorVersion      = MAJOR_ONE;
            v.functionSwitchCmd = 1'b1;
        end
        else if (s.baseSpecVersion == BASE_V2_0)
        begin
            // a version 4 or extended code without the version 3 flag stays reserved
            if (!s.version3Flag && !s.version4Flag && s.extendedSpecVersion == EXT_NONE)
            begin
                v.reserved     = 1'b0;
                v.majorVersion = MAJOR_TWO;
            end
            else if (s.version3Flag && s.extendedSpecVersion == EXT_NONE)
            begin
                v.reserved     = 1'b0;
                v.majorVersion = s.version4Flag ? MAJOR_FOUR : MAJOR_THREE;
            end
            else if (s.version3Flag && s.extendedSpecVersion <= EXT_V_MAX)
            begin
                v.reserved     = 1'b0;
                v.majorVersion = s.extendedSpecVersion + MAJOR_EXT_OFS;
            end
            // every later version keeps the commands of version 2.00
            v.functionSwitchCmd     = !v.reserved;
            v.interfaceConditionCmd = !v.reserved;
            v.lockUnlockCmd         = !v.reserved;
        end
        return v;
    endfunction : decodeVersion

    // byte-lane merge shared by both writable 16-bit registers;
    // lanes 2 and 3 carry nothing for them and are ignored
    function automatic logic [15:0] mergeLanes(input logic [15:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0]  lanes);
        logic [15:0] m;
        m = old;
        if (lanes[0])
            m[7:0] = data[7:0];
        if (lanes[1])
            m[15:8] = data[15:8];
        return m;
    endfunction : mergeLanes

    localparam logic [27:0] CAP_FIELD = clampCapacity(CAPACITY_SIZE);

    // card specific data, layout version 3.0
    // copy and protect bits stay zero; the crc comes in as a parameter
    localparam logic [127:0] CSD_IMAGE = {
        CSD_LAYOUT_V3,
        6'h00,
        CSD_ACCESS_T,
        CSD_ACCESS_N,
        CSD_SPEED,
        COMMAND_CLASS,
        CSD_BLK_LEN,
        3'h0,
        DRIVER_PRESENT,
        CAP_FIELD,
        1'b0,
        1'b1,
        SECTOR_SPAN,
        PROTECT_SPAN,
        PROTECT_ON,
        2'h0,
        CSD_R2W,
        CSD_BLK_LEN,
        6'h00,
        1'b0,
        3'h0,
        2'h0,
        1'b0,
        1'b0,
        CSD_CRC,
        1'b1
    };

    // fixed at build time; the bus has no path that writes it
    localparam card_configuration_s CFG_IMAGE = '{
        configLayoutVersion : CFG_LAYOUT_V1,
        baseSpecVersion     : BASE_SPEC,
        dataAfterErase      : ERASE_VALUE,
        copyProtectLevel    : PROTECT_LEVEL,
        supportedLaneWidths : LANE_WIDTHS,
        version3Flag        : SPEC3_FLAG,
        extendedProtection  : EXT_PROTECT,
        version4Flag        : SPEC4_FLAG,
        extendedSpecVersion : SPEC_EXT,
        reservedBit         : 1'b0,
        commandSupport      : CMD_SUPPORT,
        makerWord           : MAKER_WORD
    };

    localparam logic [63:0]   CFG_BITS = CFG_IMAGE;
    localparam version_info_s VER_INFO = decodeVersion(CFG_IMAGE);
    // units of 512 KB; no protected area, so this is all user space
    localparam logic [28:0]   CAP_UNITS = {1'b0, CAP_FIELD} + 29'h1;

    logic [31:0]      readDataQ;
    logic [31:0]      readDataD;
    logic             waitReqQ;
    logic             waitReqD;
    logic [15:0]      rcaQ;
    logic [15:0]      dsrQ;
    card_state_e      stateQ;
    card_state_e      stateD;
    version_info_s    verQ;
    logic             accept;
    logic             commit;

    // one wait cycle per access: gives a registered read path
    // a request still held at the answer edge is not taken twice, since
    // the wait flag only returns high on that same edge
    assign accept = (avReq.read || avReq.write) && waitReqQ;
    assign commit = avReq.write && !waitReqQ;

    always_comb
    begin
        waitReqD = 1'b1;
        if (accept)
            waitReqD = 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            waitReqQ <= 1'b1;
        else
            waitReqQ <= waitReqD;
    end

    // unmapped offsets read zero, so a probing host sees no alias
    always_comb
    begin
        readDataD = '0;
        if (avReq.address == OFS_CSD_W0)
            readDataD = CSD_IMAGE[31:0];
        else if (avReq.address == OFS_CSD_W1)
            readDataD = CSD_IMAGE[63:32];
        else if (avReq.address == OFS_CSD_W2)
            readDataD = CSD_IMAGE[95:64];
        else if (avReq.address == OFS_CSD_W3)
            readDataD = CSD_IMAGE[127:96];
        else if (avReq.address == OFS_RCA)
            readDataD = {16'h0000, rcaQ};
        else if (avReq.address == OFS_DSR)
            readDataD = {16'h0000, dsrQ};
        else if (avReq.address == OFS_SCR_LO)
            readDataD = CFG_BITS[31:0];
        else if (avReq.address == OFS_SCR_HI)
            readDataD = CFG_BITS[63:32];
        else if (avReq.address == OFS_STATUS)
            readDataD = {23'h000000, stateQ == CARD_TRANSFER, verQ};
        else if (avReq.address == OFS_CAPACITY)
            readDataD = {3'h0, CAP_UNITS};
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            readDataQ <= '0;
        else if (accept && avReq.read)
            readDataQ <= readDataD;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            rcaQ <= RCA_RESET;
        else if (commit && avReq.address == OFS_RCA)
            rcaQ <= mergeLanes(rcaQ, avReq.writeData, avReq.byteEnable);
    end

    // an absent driver stage reads zero and ignores writes
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            dsrQ <= DSR_START;
        else if (commit && DRIVER_PRESENT && avReq.address == OFS_DSR)
            dsrQ <= mergeLanes(dsrQ, avReq.writeData, avReq.byteEnable);
    end

    // a select for another card, or the reserved address, drops to stand-by
    always_comb
    begin
        stateD = stateQ;
        if (selectValid)
        begin
            if (selectAddr == RCA_DESELECT)
                stateD = CARD_STANDBY;
            else if (selectAddr == rcaQ)
                stateD = CARD_TRANSFER;
            else
                stateD = CARD_STANDBY;
        end
        // an unused state code falls back to stand-by
        case (stateQ)
            CARD_STANDBY:  ;
            CARD_TRANSFER: ;
            default:       stateD = CARD_STANDBY;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            stateQ <= CARD_STANDBY;
        else
            stateQ <= stateD;
    end

    // the decode is informative only; a host still checks the support bits
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            verQ <= VER_INFO;
        else
            verQ <= VER_INFO;
    end

    // the select answer leaves on the edge that takes the select
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            cardSelected <= 1'b0;
        else
            cardSelected <= stateD == CARD_TRANSFER;
    end

    // port copies trail the registers by one edge; bus reads see the live value
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            relativeCardAddress <= RCA_RESET;
        else
            relativeCardAddress <= rcaQ;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            driverStage <= DSR_START;
        else
            driverStage <= dsrQ;
    end

    assign avReadData    = readDataQ;
    assign avWaitRequest = waitReqQ;
    assign versionInfo   = verQ;

endmodule : card_config_registers
